// ### scu_top.sv
// System control and register update bank behind the serial control port.
// Assumes the port decoder hands over single-byte reads and writes on clk,
// which is the serial clock domain, and that the external pin is asynchronous.
`timescale 1ns/1ps
`include "scu_cfg.svh"
module scu_top #(
    parameter int ADDR_W = 10  // Register address width
) (
    input wire logic clk,  // Serial clock domain clock
    input wire logic nrst,  // Asynchronous reset, active low
    input wire logic wr_en,  // Write strobe, one cycle
    input wire logic rd_en,  // Read strobe, one cycle
    input wire scu_pkg::scu_addr_t addr,  // Register address
    input wire scu_pkg::scu_data_t wdata,  // Write data
    input wire logic sync_pin_n,  // External alignment pin, low asserts
    output scu_pkg::scu_data_t rdata,  // Read data, one cycle after rd_en
    output logic rvalid,  // Read data valid pulse
    output logic update_strobe,  // Buffer-to-active copy pulse for the system control register
    output logic sync_pd,  // Alignment circuitry powered down
    output logic dist_ref_pd,  // Distribution reference powered down
    output logic sync_hold,  // Selected channels forced static
    output logic sync_start  // Alignment event start pulse
);
    import scu_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Width check at elaboration; the decode below only knows 10-bit offsets
    if (ADDR_W != 10) begin : g_addr_w_check
        $error("ADDR_W must be 10");
    end

    ////////////////////////////////////////////////////////////////////////
    // Storage
    scu_sysctl_t buf_reg;  // Buffered system control, written by host
    scu_sysctl_t buf_next;  // Next buffered value
    scu_sysctl_t act_reg;  // Active system control, drives logic
    logic pend_reg;  // Update requested, waiting for copy edge
    logic pend_next;  // Next pending flag
    logic strobe_reg;  // Copy pulse
    scu_data_t rdata_reg;  // Read data holding
    scu_data_t rdata_next;  // Read mux result
    logic rvalid_reg;  // Read valid pulse

    // Full address compare; a partial decode would alias the bank across the map
    function automatic logic addr_hit(input scu_addr_t a, input scu_addr_t offset);
        return (a == offset);
    endfunction

    // Decode
    wire sel_sysctl = addr_hit(addr, `SCU_SYSCTL_ADDR);  // System control hit
    wire sel_update = addr_hit(addr, `SCU_UPDATE_ADDR);  // Update register hit
    wire sysctl_wr = wr_en & sel_sysctl;  // Buffer write
    wire update_wr = wr_en & sel_update & wdata[`SCU_UPDATE_BIT];  // Update request

    // Host writes land in the buffer only, so several fields change together
    assign buf_next = sysctl_wr ? wdata[2:0] : buf_reg;

    // Request set wins over the self-clear in the same cycle
    assign pend_next = update_wr | 1'b0;

    // Read mux; reads show the buffer and the pending flag, others read zero
    assign rdata_next = sel_sysctl ? {5'h00, buf_reg} :
                        sel_update ? {7'h00, pend_reg} : `SCU_RDATA_RST;

    ////////////////////////////////////////////////////////////////////////
    // Buffer register and update request
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            buf_reg <= `SCU_SYSCTL_RST;
            pend_reg <= `SCU_UPDATE_RST;
        end else begin
            buf_reg <= buf_next;
            pend_reg <= pend_next;
        end
    end

    // Copy to active on the edge after the request
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            act_reg <= `SCU_SYSCTL_RST;
            strobe_reg <= 1'b0;
        end else begin
            act_reg <= pend_reg ? buf_reg : act_reg;
            strobe_reg <= pend_reg;
        end
    end

    // Registered read answer
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rdata_reg <= `SCU_RDATA_RST;
            rvalid_reg <= 1'b0;
        end else begin
            rdata_reg <= rd_en ? rdata_next : rdata_reg;
            rvalid_reg <= rd_en;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs straight from flops
    assign rdata = rdata_reg;
    assign rvalid = rvalid_reg;
    assign update_strobe = strobe_reg;
    assign sync_pd = act_reg[`SCU_SYNC_PD_BIT];
    assign dist_ref_pd = act_reg[`SCU_DREF_PD_BIT];

    // Pin and soft bit merge; the soft bit acts from the active copy
    scu_sync_detect u_sync (
        .clk(clk),
        .nrst(nrst),
        .sync_pin_n(sync_pin_n),
        .soft_sync(act_reg[`SCU_SOFT_SYNC_BIT]),
        .sync_pd(act_reg[`SCU_SYNC_PD_BIT]),
        .hold(sync_hold),
        .start(sync_start)
    );

    ////////////////////////////////////////////////////////////////////////
    // Checks
    property p_update_take;
        @(posedge clk) disable iff (!nrst) update_wr |=> pend_reg ##1 strobe_reg;
    endproperty
    a_update_take: assert property (p_update_take) else $error("update not taken");

    property p_copy;
        @(posedge clk) disable iff (!nrst) pend_reg |=> (act_reg == $past(buf_reg));
    endproperty
    a_copy: assert property (p_copy) else $error("active not loaded from buffer");

    property p_self_clear;
        @(posedge clk) disable iff (!nrst) (pend_reg && !update_wr) |=> !pend_reg;
    endproperty
    a_self_clear: assert property (p_self_clear) else $error("update bit stuck");

    property p_hold_act;
        @(posedge clk) disable iff (!nrst) !pend_reg |=> $stable(act_reg);
    endproperty
    a_hold_act: assert property (p_hold_act) else $error("active changed without update");

    property p_sync_pd;
        @(posedge clk) disable iff (!nrst)
            (pend_reg && buf_reg[`SCU_SYNC_PD_BIT]) |=> sync_pd ##1 (!sync_hold && !sync_start);
    endproperty
    a_sync_pd: assert property (p_sync_pd) else $error("alignment not powered down");

    property p_dref_pd;
        @(posedge clk) disable iff (!nrst)
            pend_reg |=> (dist_ref_pd == $past(buf_reg[`SCU_DREF_PD_BIT]));
    endproperty
    a_dref_pd: assert property (p_dref_pd) else $error("reference power-down wrong");

    property p_soft_hold;
        @(posedge clk) disable iff (!nrst)
            (act_reg[`SCU_SOFT_SYNC_BIT] && !sync_pd) |=> sync_hold;
    endproperty
    a_soft_hold: assert property (p_soft_hold) else $error("soft bit did not force static");

    property p_start_pulse;
        @(posedge clk) disable iff (!nrst) sync_start |=> !sync_start;
    endproperty
    a_start_pulse: assert property (p_start_pulse) else $error("start longer than one cycle");

    property p_soft_default;
        @(posedge clk) disable iff (!nrst)
            (!act_reg[`SCU_SOFT_SYNC_BIT] && sync_pin_n) [*3] |=> !sync_hold;
    endproperty
    a_soft_default: assert property (p_soft_default) else $error("soft zero not like pin high");

    property p_unmapped;
        @(posedge clk) disable iff (!nrst) (rd_en && !sel_sysctl && !sel_update) |=>
            (rvalid && rdata == 8'h00);
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

    // Read port answers: every strobe gives exactly one valid pulse
    property p_read_answer;
        @(posedge clk) disable iff (!nrst) rd_en |=> rvalid;
    endproperty
    a_read_answer: assert property (p_read_answer) else $error("read answer missing");

    property p_read_quiet;
        @(posedge clk) disable iff (!nrst) !rd_en |=> !rvalid;
    endproperty
    a_read_quiet: assert property (p_read_quiet) else $error("valid without a read");

    // Reads show the buffered copy, so the host can check its loads before commit
    property p_read_sysctl;
        @(posedge clk) disable iff (!nrst) (rd_en && sel_sysctl) |=>
            (rdata == {5'h00, $past(buf_reg)});
    endproperty
    a_read_sysctl: assert property (p_read_sysctl) else $error("control read wrong");

    // The update bit reads back set only while the copy is still pending
    property p_read_pending;
        @(posedge clk) disable iff (!nrst) (rd_en && sel_update) |=>
            (rdata == {7'h00, $past(pend_reg)});
    endproperty
    a_read_pending: assert property (p_read_pending) else $error("update read wrong");

    // A copy pulse only ever follows a pending request
    property p_no_stray_strobe;
        @(posedge clk) disable iff (!nrst) !pend_reg |=> !update_strobe;
    endproperty
    a_no_stray_strobe: assert property (p_no_stray_strobe) else $error("stray copy");

    // A plain buffer write must never reach the active copy by itself
    property p_write_buffered;
        @(posedge clk) disable iff (!nrst) (sysctl_wr && !pend_reg) |=> $stable(act_reg);
    endproperty
    a_write_buffered: assert property (p_write_buffered) else $error("write bypassed buffer");

    // Main scenarios: a copy, a static hold, and a soft release starting alignment
    c_update: cover property (@(posedge clk) disable iff (!nrst) strobe_reg);
    c_hold: cover property (@(posedge clk) disable iff (!nrst) sync_hold);
    c_soft_start: cover property (@(posedge clk) disable iff (!nrst)
        $fell(act_reg[`SCU_SOFT_SYNC_BIT]) ##1 sync_start);
endmodule

// ### scu_cfg.svh
// Constants for the system control and register update bank.
// Assumes a 10-bit register address and 8-bit data from the serial control port.
`ifndef SCU_CFG_SVH
`define SCU_CFG_SVH

// Register offsets
`define SCU_SYSCTL_ADDR 10'h230
`define SCU_UPDATE_ADDR 10'h232

// Field positions inside the system control register
`define SCU_SYNC_PD_BIT 2
`define SCU_DREF_PD_BIT 1
`define SCU_SOFT_SYNC_BIT 0

// Field position inside the update register
`define SCU_UPDATE_BIT 0

// Reset values
`define SCU_SYSCTL_RST 3'h0
`define SCU_UPDATE_RST 1'h0
`define SCU_RDATA_RST 8'h00

`endif

// ### scu_pkg.sv
// Types shared by the system control and register update bank.
// Assumes scu_cfg.svh holds all offsets and reset values.
package scu_pkg;
    typedef logic [9:0] scu_addr_t;  // Register address
    typedef logic [7:0] scu_data_t;  // Register data
    typedef logic [2:0] scu_sysctl_t;  // Implemented system control bits
endpackage

// ### scu_sync_detect.sv
// Output alignment trigger: merges the external alignment pin with the soft bit.
// Assumes the pin is asynchronous to clk and the soft bit comes from clk logic.
`timescale 1ns/1ps
module scu_sync_detect (
    input wire logic clk,  // System clock
    input wire logic nrst,  // Asynchronous reset, active low
    input wire logic sync_pin_n,  // External alignment pin, low asserts
    input wire logic soft_sync,  // Soft alignment bit, high asserts
    input wire logic sync_pd,  // Alignment circuitry powered down
    output logic hold,  // Channels forced static
    output logic start  // One-cycle alignment start
);
    ////////////////////////////////////////////////////////////////////////
    logic pin_s1_reg;  // First synchroniser stage
    logic pin_s2_reg;  // Second synchroniser stage
    logic asrt_reg;  // Previous merged assert level
    logic hold_reg;  // Registered hold
    logic start_reg;  // Registered start
    wire asrt;  // Merged assert level
    wire enable;  // Circuitry powered

    // Soft bit has reversed sense versus the pin
    assign asrt = soft_sync | ~pin_s2_reg;
    assign enable = ~sync_pd;
    assign hold = hold_reg;
    assign start = start_reg;

    ////////////////////////////////////////////////////////////////////////
    // Two-stage synchroniser; reset to pin-high so no false start
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pin_s1_reg <= 1'b1;
            pin_s2_reg <= 1'b1;
        end else begin
            pin_s1_reg <= sync_pin_n;
            pin_s2_reg <= pin_s1_reg;
        end
    end

    // Hold while asserted; start on release of assertion
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            asrt_reg <= 1'b0;
            hold_reg <= 1'b0;
            start_reg <= 1'b0;
        end else begin
            asrt_reg <= asrt;
            hold_reg <= enable & asrt;
            start_reg <= enable & asrt_reg & ~asrt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    property p_hold_soft;
        @(posedge clk) disable iff (!nrst) (soft_sync && !sync_pd) |=> hold_reg;
    endproperty
    a_hold_soft: assert property (p_hold_soft) else $error("soft bit did not hold");

    property p_start_edge;
        @(posedge clk) disable iff (!nrst)
            (asrt_reg && !asrt && !sync_pd) |=> (start_reg ##1 !start_reg);
    endproperty
    a_start_edge: assert property (p_start_edge) else $error("no single start pulse");

    property p_idle_free;
        @(posedge clk) disable iff (!nrst) (!soft_sync && pin_s2_reg) |=> !hold_reg;
    endproperty
    a_idle_free: assert property (p_idle_free) else $error("hold without assertion");

    property p_pd_quiet;
        @(posedge clk) disable iff (!nrst) sync_pd |=> (!hold_reg && !start_reg);
    endproperty
    a_pd_quiet: assert property (p_pd_quiet) else $error("active while powered down");

    c_start: cover property (@(posedge clk) disable iff (!nrst) start_reg);
endmodule

// ### scu_host_model.sv
// Host controller model for the register port: single-byte writes and reads.
// Assumes the bank samples requests on the rising clk edge and answers with rvalid.
`timescale 1ns/1ps
module scu_host_model (
    input wire logic clk,  // Port clock
    output logic wr_en,  // Write strobe
    output logic rd_en,  // Read strobe
    output scu_pkg::scu_addr_t addr,  // Register address
    output scu_pkg::scu_data_t wdata,  // Write data
    input wire scu_pkg::scu_data_t rdata,  // Read data
    input wire logic rvalid  // Read data valid
);
    import scu_pkg::*;
    ////////////////////////////////////////////////////////////////////////////////
    // Idle bus; address and data show a junk pattern when not qualified
    initial begin
        wr_en = 1'b0;
        rd_en = 1'b0;
        addr = 10'h3ff;
        wdata = 8'hff;
    end
    // One write; held across one sampling edge, then the lines are scrambled
    task automatic wr(input scu_addr_t a, input scu_data_t d);
        @(posedge clk);
        #1;
        wr_en = 1'b1;
        addr = a;
        wdata = d;
        @(posedge clk);
        #1;
        wr_en = 1'b0;
        addr = ~a;
        wdata = ~d;
    endtask
    // One read; ok stays low if rvalid never shows within the bound
    task automatic rd(input scu_addr_t a, output scu_data_t d, output logic ok);
        ok = 1'b0;
        d = 8'h00;
        @(posedge clk);
        #1;
        rd_en = 1'b1;
        addr = a;
        @(posedge clk);
        #1;
        rd_en = 1'b0;
        addr = ~a;
        for (int i = 0; i < 4 && !ok; i++) begin
            if (rvalid === 1'b1) begin
                ok = 1'b1;
                d = rdata;
            end else begin
                @(posedge clk);
                #1;
            end
        end
    endtask
    // Buffers first, commit last, so the active settings change in one step
    task automatic load_commit(input scu_data_t d);
        wr(10'h230, d);
        wr(10'h232, 8'h01);
    endtask
endmodule

// ### test_system_ctrl_update_regs.sv
// Self-checking bench for the system control and register update bank.
// Assumes scu_top and the host model above; pin driven here, 100 MHz clock.
`timescale 1ns/1ps
module test_system_ctrl_update_regs;
    import scu_pkg::*;
    logic clk;  // Clock
    logic nrst;  // Reset, active low
    logic sync_pin_n;  // External alignment pin
    logic wr_en, rd_en, rvalid, update_strobe, sync_pd, dist_ref_pd, sync_hold, sync_start;
    scu_addr_t addr;  // Address from host
    scu_data_t wdata, rdata;  // Data both ways
    int miscompares = 0;  // Mismatch count
    int cmp_count = 0;  // Comparison count
    scu_top u_scu_top (.clk(clk), .nrst(nrst), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
        .wdata(wdata), .sync_pin_n(sync_pin_n), .rdata(rdata), .rvalid(rvalid),
        .update_strobe(update_strobe), .sync_pd(sync_pd), .dist_ref_pd(dist_ref_pd),
        .sync_hold(sync_hold), .sync_start(sync_start));
    scu_host_model u_scu_host_model (.clk(clk), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
        .wdata(wdata), .rdata(rdata), .rvalid(rvalid));
    ////////////////////////////////////////////////////////////////////////////////
    initial clk = 1'b0;
    always #5 clk = ~clk;
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("compares=%0d mismatches=%0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // Bounded wait: 0 strobe, 1 hold, 2 start; a missing must-see ends the run
    task automatic wait_for(input int sel, input int n, input bit must, output logic hit);
        hit = 1'b0;
        for (int i = 0; i < n && hit !== 1'b1; i++) begin
            @(posedge clk);
            #1;
            hit = (sel == 0) ? update_strobe : (sel == 1) ? sync_hold : sync_start;
        end
        if (must && hit !== 1'b1) begin
            miscompares++;
            report_and_stop();
        end
    endtask
    task automatic rd_chk(input scu_addr_t a, input scu_data_t exp);
        scu_data_t d;
        logic ok;
        u_scu_host_model.rd(a, d, ok);
        chk({7'h00, ok}, 8'h01);
        chk(d, exp);
    endtask
    // Commit and check the four control outputs afterwards
    task automatic commit(input scu_data_t d, input logic [3:0] exp);
        logic hit;
        u_scu_host_model.load_commit(d);
        wait_for(0, 8, 1'b1, hit);
        @(posedge clk);
        #1;
        chk({4'h0, sync_pd, dist_ref_pd, sync_hold, sync_start}, {4'h0, exp});
        rd_chk(10'h232, 8'h00);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_power();
        rd_chk(10'h230, 8'h00);
        u_scu_host_model.wr(10'h230, 8'hfc);
        chk({7'h00, sync_pd}, 8'h00);
        rd_chk(10'h230, 8'h04);
        commit(8'hfc, 4'h8);
        commit(8'h02, 4'h4);
        commit(8'h00, 4'h0);
        u_scu_host_model.wr(10'h231, 8'hff);
        rd_chk(10'h231, 8'h00);
        rd_chk(10'h230, 8'h00);
        $display("test power done");
    endtask
    task automatic t_soft();
        logic hit;
        commit(8'h01, 4'h2);
        commit(8'h00, 4'h1);
        wait_for(2, 6, 1'b0, hit);
        chk({7'h00, hit}, 8'h00);
        commit(8'h01, 4'h2);
        u_scu_host_model.load_commit(8'h00);
        wait_for(2, 8, 1'b1, hit);
        @(posedge clk);
        #1;
        chk({6'h00, sync_hold, sync_start}, 8'h00);
        $display("test soft done");
    endtask
    task automatic t_gate();
        logic hit;
        commit(8'h05, 4'h8);
        commit(8'h04, 4'h8);
        wait_for(2, 6, 1'b0, hit);
        chk({7'h00, hit}, 8'h00);
        commit(8'h00, 4'h0);
        sync_pin_n = 1'b0;
        wait_for(1, 6, 1'b1, hit);
        sync_pin_n = 1'b1;
        wait_for(2, 6, 1'b1, hit);
        $display("test gate done");
    endtask
    // Mid-run reset: active copy, outputs and buffers all fall back to defaults
    task automatic t_reset();
        commit(8'h06, 4'hc);
        @(posedge clk);
        #1;
        nrst = 1'b0;
        #1;
        chk({3'h0, update_strobe, sync_pd, dist_ref_pd, sync_hold, sync_start}, 8'h00);
        chk(rdata, 8'h00);
        repeat (2) @(posedge clk);
        #1;
        nrst = 1'b1;
        chk({3'h0, update_strobe, sync_pd, dist_ref_pd, sync_hold, sync_start}, 8'h00);
        rd_chk(10'h230, 8'h00);
        rd_chk(10'h232, 8'h00);
        $display("test reset done");
    endtask
    initial begin
        nrst = 1'b0;
        sync_pin_n = 1'b1;
        repeat (20) @(posedge clk);
        #1;
        nrst = 1'b1;
        t_power();
        t_soft();
        t_gate();
        t_reset();
        report_and_stop();
    end
endmodule
